/* hdl/qir_index_reset.sv */
`timescale 1ns/1ps
`include "qir_consts.svh"
module qir_index_reset #(
  parameter int CW = 32
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // encoder pins
  input wire qir_pkg::qir_pins_t pins_i,
  // register port
  input wire qir_pkg::qir_bus_t bus_i,
  output logic [31:0] rdata_o,
  // interrupt
  output logic irq_o
);
  import qir_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] prev_reg;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      prev_reg <= 3'h0;
    end else begin
      sync1_reg <= {pins_i.idx, pins_i.qb, pins_i.qa};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  logic qa, qb, idx, qa_p, qb_p, idx_p;
  assign qa = sync2_reg[0];
  assign qb = sync2_reg[1];
  assign idx = sync2_reg[2];
  assign qa_p = prev_reg[0];
  assign qb_p = prev_reg[1];
  assign idx_p = prev_reg[2];

  // ----------------------------------------
  // warm-up after reset
  // ----------------------------------------
  // no edges until prev_reg holds a real pin sample, not a reset value
  logic [2:0] prime_reg;
  logic live;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prime_reg <= '0;
    end else begin
      prime_reg <= {prime_reg[1:0], 1'b1};
    end
  end
  assign live = prime_reg[2];

  // ----------------------------------------
  // quadrature edge and direction
  // ----------------------------------------
  // edge code: {which line moved, new level}
  function automatic logic [1:0] edge_code(input logic a, input logic b,
                                           input logic ap);
    edge_code = (a != ap) ? {1'b0, a} : {1'b1, b};
  endfunction : edge_code

  logic step;
  logic fwd_step;
  logic [1:0] cur_edge;
  assign step = live & ((qa != qa_p) ^ (qb != qb_p));
  // forward when a leads b
  assign fwd_step = (qa != qa_p) ? (qa != qb) : (qa == qb);
  assign cur_edge = edge_code(qa, qb, qa_p);

  logic dir_reg;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dir_reg <= 1'b1;
    end else if (step) begin
      dir_reg <= fwd_step;
    end
  end
  logic dir_now;
  assign dir_now = step ? fwd_step : dir_reg;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [3:0] ctrl_reg;
  logic [CW-1:0] max_reg;
  logic [CW-1:0] count_reg;
  logic seen_reg;
  logic fdir_reg;
  logic [1:0] edge_reg;
  logic [`QIR_IRQ_W-1:0] ists_reg;
  logic [`QIR_IRQ_W-1:0] ien_reg;
  logic [1:0] mode;
  logic fix_mode;
  logic init_mode;
  assign mode = ctrl_reg[`QIR_CTRL_MODE_MSB:`QIR_CTRL_MODE_LSB];
  assign fix_mode = ctrl_reg[`QIR_CTRL_FIX_BIT];
  assign init_mode = ctrl_reg[`QIR_CTRL_INIT_BIT];

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg <= 4'h0;
      max_reg <= CW'(`QIR_MAX_RESET);
      ien_reg <= '0;
    end else if (bus_i.wr) begin
      case (bus_i.addr)
        `QIR_ADDR_CTRL: ctrl_reg <= bus_i.wdata[3:0];
        `QIR_ADDR_MAX: max_reg <= bus_i.wdata[CW-1:0];
        `QIR_ADDR_IRQ_EN: ien_reg <= bus_i.wdata[`QIR_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // index event handling
  // ----------------------------------------
  logic idx_rise;
  logic first_ev;
  logic armed_reg;
  logic stuck_dir_reg;
  logic do_reset;
  logic reset_dir;
  assign idx_rise = live & idx & ~idx_p;
  // first index: latch on the first quadrature edge inside the pulse
  assign first_ev = ~seen_reg & idx & step;

  // arm on each index pulse once the first index is seen, disarm at end or after one reset
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      armed_reg <= 1'b0;
      stuck_dir_reg <= 1'b1;
    end else if (idx_rise) begin
      armed_reg <= seen_reg;
      stuck_dir_reg <= dir_now;
    end else if (~idx | do_reset) begin
      armed_reg <= 1'b0;
    end
  end

  always_comb begin
    do_reset = 1'b0;
    reset_dir = dir_now;
    if (mode == `QIR_MODE_ON_INDEX && !init_mode && seen_reg) begin
      do_reset = armed_reg & idx & step & (cur_edge == edge_reg);
      reset_dir = fix_mode ? dir_now : stuck_dir_reg;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_reg <= CW'(`QIR_ZERO_COUNT);
    end else if (bus_i.wr && bus_i.addr == `QIR_ADDR_COUNT) begin
      count_reg <= bus_i.wdata[CW-1:0];
    end else if (init_mode && idx_rise) begin
      count_reg <= CW'(`QIR_ZERO_COUNT);
    end else if (do_reset || (first_ev && mode == `QIR_MODE_ON_INDEX)) begin
      count_reg <= (do_reset ? reset_dir : dir_now) ?
                   CW'(`QIR_ZERO_COUNT) : max_reg;
    end else if (step) begin
      count_reg <= fwd_step ? count_reg + CW'(1) : count_reg - CW'(1);
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      seen_reg <= 1'b0;
      fdir_reg <= 1'b0;
      edge_reg <= 2'h0;
    end else if (first_ev) begin
      seen_reg <= 1'b1;
      fdir_reg <= dir_now;
      edge_reg <= cur_edge;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [`QIR_IRQ_W-1:0] iset;
  logic [`QIR_IRQ_W-1:0] iclr;
  logic [`QIR_IRQ_W-1:0] ien_next;
  assign ien_next = (bus_i.wr && bus_i.addr == `QIR_ADDR_IRQ_EN) ?
                    bus_i.wdata[`QIR_IRQ_W-1:0] : ien_reg;
  always_comb begin
    iset = '0;
    iset[`QIR_IRQ_RESET_BIT] = do_reset;
    iset[`QIR_IRQ_FIRST_BIT] = first_ev;
    iclr = '0;
    if (bus_i.wr && bus_i.addr == `QIR_ADDR_IRQ_CLR) begin
      iclr = bus_i.wdata[`QIR_IRQ_W-1:0];
    end
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ists_reg <= '0;
    end else begin
      ists_reg <= (ists_reg & ~iclr) | iset;
    end
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((ists_reg & ~iclr) | iset) & ien_next);
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [31:0] rd_next;
  always_comb begin
    rd_next = 32'h0000_0000;
    case (bus_i.addr)
      `QIR_ADDR_CTRL: rd_next[3:0] = ctrl_reg;
      `QIR_ADDR_MAX: rd_next[CW-1:0] = max_reg;
      `QIR_ADDR_COUNT: rd_next[CW-1:0] = count_reg;
      `QIR_ADDR_STATUS: begin
        rd_next[`QIR_STS_SEEN_BIT] = seen_reg;
        rd_next[`QIR_STS_DIR_BIT] = fdir_reg;
      end
      `QIR_ADDR_IRQ_STAT: rd_next[`QIR_IRQ_W-1:0] = ists_reg;
      `QIR_ADDR_IRQ_EN: rd_next[`QIR_IRQ_W-1:0] = ien_reg;
      default: rd_next = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (bus_i.rd) begin
      rdata_o <= rd_next;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_fix_reset;
    do_reset && reset_dir && !(bus_i.wr && bus_i.addr == `QIR_ADDR_COUNT);
  endsequence
  sequence s_rev_reset;
    do_reset && !reset_dir && !(bus_i.wr && bus_i.addr == `QIR_ADDR_COUNT)
      && !(init_mode && idx_rise);
  endsequence

  a_fwd_zero: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_fix_reset |=> count_reg == CW'(`QIR_ZERO_COUNT))
    else $error("forward index reset did not zero count");
  a_rev_max: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_rev_reset |=> count_reg == $past(max_reg))
    else $error("reverse index reset did not load maximum");
  a_first_seen: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    first_ev |=> seen_reg && ists_reg[`QIR_IRQ_FIRST_BIT])
    else $error("first index not flagged");
  a_first_dir: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    first_ev |=> fdir_reg == $past(dir_now))
    else $error("first index direction not captured");
  a_edge_match: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    do_reset |-> cur_edge == edge_reg && idx)
    else $error("index reset on wrong edge");
  a_one_reset: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    do_reset |=> !armed_reg)
    else $error("second reset possible in one index pulse");
  a_fix_dir: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    do_reset && fix_mode |-> reset_dir == dir_now)
    else $error("fixed mode ignored present direction");
  a_init_safe: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    init_mode |-> !do_reset)
    else $error("initialise mode used edge search");
  a_irq_level: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    ##1 irq_o == |(ists_reg & ien_reg))
    else $error("interrupt output mismatch");

  sequence s_first_fwd;
    first_ev && mode == `QIR_MODE_ON_INDEX && dir_now && !init_mode
      && !(bus_i.wr && bus_i.addr == `QIR_ADDR_COUNT);
  endsequence
  sequence s_first_rev;
    first_ev && mode == `QIR_MODE_ON_INDEX && !dir_now && !init_mode
      && !(bus_i.wr && bus_i.addr == `QIR_ADDR_COUNT);
  endsequence
  a_first_fwd: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_first_fwd |=> count_reg == CW'(`QIR_ZERO_COUNT))
    else $error("first forward index did not zero count");
  a_first_rev: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_first_rev |=> count_reg == $past(max_reg))
    else $error("first reverse index did not load maximum");
  a_first_once: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    seen_reg |-> !first_ev)
    else $error("first index latched twice");
  a_legacy_dir: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    do_reset && !fix_mode |-> reset_dir == stuck_dir_reg)
    else $error("legacy mode lost index rise direction");
  a_clean_recover: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    do_reset && stuck_dir_reg == dir_now
      && !(bus_i.wr && bus_i.addr == `QIR_ADDR_COUNT)
      |=> count_reg == ($past(dir_now) ? CW'(`QIR_ZERO_COUNT)
                                       : $past(max_reg)))
    else $error("index without reversal did not reset correctly");
  a_init_zero: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    init_mode && idx_rise && !(bus_i.wr && bus_i.addr == `QIR_ADDR_COUNT)
      |=> count_reg == CW'(`QIR_ZERO_COUNT))
    else $error("index-event initialise did not zero count");
  a_read_idle: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    !bus_i.rd |=> rdata_o == 32'h0000_0000)
    else $error("read data not idle outside a read");
endmodule : qir_index_reset

/* pkg/qir_consts.svh */
`ifndef QIR_CONSTS_SVH
`define QIR_CONSTS_SVH
// register offsets
`define QIR_ADDR_CTRL 4'h0
`define QIR_ADDR_MAX 4'h1
`define QIR_ADDR_COUNT 4'h2
`define QIR_ADDR_STATUS 4'h3
`define QIR_ADDR_IRQ_STAT 4'h4
`define QIR_ADDR_IRQ_CLR 4'h5
`define QIR_ADDR_IRQ_EN 4'h6
// control fields
`define QIR_CTRL_MODE_LSB 0
`define QIR_CTRL_MODE_MSB 1
`define QIR_CTRL_FIX_BIT 2
`define QIR_CTRL_INIT_BIT 3
// reset-on-index mode encoding
`define QIR_MODE_ON_INDEX 2'h0
// status fields
`define QIR_STS_SEEN_BIT 0
`define QIR_STS_DIR_BIT 1
// irq bits
`define QIR_IRQ_RESET_BIT 0
`define QIR_IRQ_FIRST_BIT 1
`define QIR_IRQ_W 2
`define QIR_ZERO_COUNT 32'h0000_0000
`define QIR_MAX_RESET 32'hffff_ffff
`endif

/* pkg/qir_pkg.sv */
package qir_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } qir_bus_t;
  typedef struct packed {
    logic qa;
    logic qb;
    logic idx;
  } qir_pins_t;
endpackage : qir_pkg

/* testbench/qir_enc_model.sv */
`timescale 1ns/1ps
module qir_enc_model (
  // clock
  input wire logic core_clk_i,
  // motion commands
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic idx_i,
  // encoder pins
  output qir_pkg::qir_pins_t pins_o
);
  import qir_pkg::*;
  logic [1:0] phase_reg = 2'h0;
  // -------------------------------------------
  // one quadrature edge per step, a leads b forward
  // -------------------------------------------
  always @(posedge core_clk_i) begin
    if (step_i) begin
      phase_reg <= dir_i ? phase_reg + 2'h1 : phase_reg - 2'h1;
    end
  end
  always_comb begin
    pins_o.qa = phase_reg[1] ^ phase_reg[0];
    pins_o.qb = phase_reg[1];
    pins_o.idx = idx_i;
  end
endmodule : qir_enc_model

/* testbench/qir_index_reset_tb_top.sv */
`timescale 1ns/1ps
`include "qir_consts.svh"
module qir_index_reset_tb_top;
  import qir_pkg::*;
  logic core_clk_i, reset_i, step, dir, idx, irq_o, rd_d;
  logic [31:0] rdata_o, mx;
  qir_bus_t bus;
  qir_pins_t pins;
  logic [31:0] expq[$];
  int failures, cmp_count;
  qir_index_reset u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .pins_i(pins), .bus_i(bus), .rdata_o(rdata_o), .irq_o(irq_o));
  qir_enc_model u_enc (.core_clk_i(core_clk_i), .step_i(step),
    .dir_i(dir), .idx_i(idx), .pins_o(pins));
  // -------------------------------------------
  // tasks
  // -------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc
  task automatic conclude;
    $display("compares=%0d failures=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic chk_irq(input logic e);
    #1;
    chk({31'h0, e}, {31'h0, irq_o});
  endtask : chk_irq
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    cyc(1);
    bus <= '0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    expq.push_back(e);
    cyc(1);
    bus <= '0;
    cyc(1);
  endtask : rd
  task automatic mv(input logic d, input int n);
    repeat (n) begin
      step <= 1'b1;
      dir <= d;
      cyc(1);
      step <= 1'b0;
      cyc(4);
    end
    cyc(4);
  endtask : mv
  // -------------------------------------------
  // read data monitor
  // -------------------------------------------
  always @(negedge core_clk_i) begin
    if (rd_d) begin
      if (expq.size() == 0) chk(32'h0, 32'hdead_0000);
      else chk(expq.pop_front(), rdata_o);
    end
    rd_d = bus.rd;
  end
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    cyc(20000);
    failures++;
    conclude();
  end
  // -------------------------------------------
  // main sequence
  // -------------------------------------------
  initial begin
    reset_i = 1'b1;
    bus = '0;
    step = 1'b0;
    dir = 1'b1;
    idx = 1'b0;
    rd_d = 1'b0;
    failures = 0;
    cmp_count = 0;
    void'($urandom(32'h18148bc7));
    mx = $urandom;
    cyc(8);
    reset_i <= 1'b0;
    cyc(1);
    rd(`QIR_ADDR_CTRL, 32'h0);
    rd(`QIR_ADDR_MAX, `QIR_MAX_RESET);
    rd(`QIR_ADDR_COUNT, `QIR_ZERO_COUNT);
    rd(`QIR_ADDR_STATUS, 32'h0);
    rd(4'hf, 32'h0);
    // corrected reset-on-index chosen, no reversal expected
    wr(`QIR_ADDR_CTRL, 32'h4);
    wr(`QIR_ADDR_IRQ_EN, 32'h3);
    mv(1'b1, 5);
    rd(`QIR_ADDR_COUNT, 32'h5);
    idx <= 1'b1;
    cyc(3);
    mv(1'b1, 1);
    idx <= 1'b0;
    mv(1'b1, 3);
    rd(`QIR_ADDR_COUNT, 32'h3);
    rd(`QIR_ADDR_STATUS, 32'h3);
    chk_irq(1'b1);
    rd(`QIR_ADDR_IRQ_STAT, 32'h2);
    wr(`QIR_ADDR_IRQ_CLR, 32'h3);
    cyc(3);
    chk_irq(1'b0);
    rd(`QIR_ADDR_IRQ_STAT, 32'h0);
    // second reset in mid-run, first index in reverse
    reset_i <= 1'b1;
    cyc(2);
    reset_i <= 1'b0;
    cyc(1);
    rd(`QIR_ADDR_STATUS, 32'h0);
    rd(`QIR_ADDR_COUNT, `QIR_ZERO_COUNT);
    wr(`QIR_ADDR_MAX, mx);
    idx <= 1'b1;
    cyc(3);
    mv(1'b0, 1);
    idx <= 1'b0;
    mv(1'b0, 2);
    rd(`QIR_ADDR_COUNT, mx - 32'h2);
    rd(`QIR_ADDR_STATUS, 32'h1);
    // index-event initialise with reversal inside the pulse
    wr(`QIR_ADDR_CTRL, 32'h8);
    wr(`QIR_ADDR_COUNT, 32'h20);
    rd(`QIR_ADDR_COUNT, 32'h20);
    idx <= 1'b1;
    cyc(4);
    mv(1'b1, 2);
    mv(1'b0, 1);
    idx <= 1'b0;
    cyc(4);
    rd(`QIR_ADDR_COUNT, 32'h1);
    // corrected mode: later index reset on the remembered edge
    wr(`QIR_ADDR_CTRL, 32'h4);
    wr(`QIR_ADDR_IRQ_EN, 32'h1);
    wr(`QIR_ADDR_IRQ_CLR, 32'h3);
    idx <= 1'b1;
    cyc(3);
    mv(1'b1, 4);
    idx <= 1'b0;
    mv(1'b1, 1);
    rd(`QIR_ADDR_COUNT, 32'h1);
    rd(`QIR_ADDR_IRQ_STAT, 32'h1);
    chk_irq(1'b1);
    wr(`QIR_ADDR_IRQ_CLR, 32'h1);
    // corrected mode, reversal inside the pulse
    idx <= 1'b1;
    cyc(3);
    mv(1'b1, 2);
    mv(1'b0, 3);
    idx <= 1'b0;
    rd(`QIR_ADDR_COUNT, mx - 32'h1);
    // legacy mode, reversal inside the pulse
    wr(`QIR_ADDR_CTRL, 32'h0);
    mv(1'b1, 1);
    idx <= 1'b1;
    cyc(3);
    mv(1'b1, 2);
    mv(1'b0, 3);
    idx <= 1'b0;
    rd(`QIR_ADDR_COUNT, 32'hffff_ffff);
    // legacy mode, next pulse without reversal
    idx <= 1'b1;
    cyc(3);
    mv(1'b0, 4);
    idx <= 1'b0;
    rd(`QIR_ADDR_COUNT, mx - 32'h1);
    cyc(3);
    conclude();
  end
endmodule : qir_index_reset_tb_top
